// ===== sdcl_pkg.sv
// package: constants for the serial code loader
package sdcl_pkg;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned FULL_COUNT = 65536;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [4:0] BITS_RST = 5'h00;
  localparam logic [4:0] BITS_FULL = 5'h10;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SCLK_MAX_HZ = 50000000;
  localparam int unsigned CS_HIGH_NS = 20;
  localparam int unsigned CLK_NS = 25;
  // least time rounds up, never below one cycle
  localparam int unsigned CS_HIGH_CYC = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    SDCL_IDLE = 2'b00,
    SDCL_SHIFT = 2'b01,
    SDCL_DONE = 2'b11
  } sdcl_state_t;
endpackage : sdcl_pkg

// ===== sdcl_pins_if.sv
// interface: synchronised serial pins passed to the shifter
`timescale 1ns/1ps
`default_nettype none
interface sdcl_pins_if;
  logic sel_n;
  logic sclk_rise;
  logic cs_rise;
  logic din;
  modport src (output sel_n, output sclk_rise, output cs_rise, output din);
  modport dst (input sel_n, input sclk_rise, input cs_rise, input din);
endinterface : sdcl_pins_if
`default_nettype wire

// ===== sdcl_sync.sv
// module: two-flop synchronisers and edge detection for the serial pins
`timescale 1ns/1ps
`default_nettype none
module sdcl_sync
  import sdcl_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset, // sync reset
  input wire logic cs_n, // chip select pin
  input wire logic sclk, // serial clock pin
  input wire logic sdi, // serial data pin
  sdcl_pins_if.src pins // synchronised pins
);
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [1:0] prev_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_r <= 3'h5;
      s2_r <= 3'h5;
    end else begin
      s1_r <= {cs_n, sclk, sdi};
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_r <= 2'h2;
    end else begin
      prev_r <= s2_r[2:1];
    end
  end

  assign pins.sel_n = s2_r[2];
  assign pins.sclk_rise = s2_r[1] & ~prev_r[0];
  assign pins.cs_rise = s2_r[2] & ~prev_r[1];
  assign pins.din = s2_r[0];
endmodule : sdcl_sync
`default_nettype wire

// ===== sdcl_loader.sv
// module: serial shift register and code register of the converter
`timescale 1ns/1ps
`default_nettype none
module sdcl_loader
  import sdcl_pkg::*;
(
  input wire logic clk, // system clock, 40 MHz
  input wire logic reset, // sync reset, active high
  input wire logic cs_n, // chip select pin, active low
  input wire logic sclk, // serial clock pin
  input wire logic sdi, // serial data pin
  output logic [15:0] serial_code_input, // code held for the ladder
  output logic word_done // high once 16 bits are in this frame
);
  sdcl_pins_if pins ();
  sdcl_state_t state_r;
  logic [15:0] shift_r;
  logic [4:0] bits_r;
  logic [15:0] code_r;

  // pins cross domains here; sclk is sampled, so the 40 MHz clock only
  // resolves serial clocks well below the 50 MHz ceiling
  sdcl_sync u_sync (
    .clk(clk),
    .reset(reset),
    .cs_n(cs_n),
    .sclk(sclk),
    .sdi(sdi),
    .pins(pins)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      shift_r <= SHIFT_RST;
    end else if (!pins.sel_n && pins.sclk_rise) begin
      shift_r <= {shift_r[14:0], pins.din};
    end
  end

  // frame state; select high always returns to idle
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= SDCL_IDLE;
    end else if (pins.sel_n) begin
      state_r <= SDCL_IDLE;
    end else begin
      unique case (state_r)
        SDCL_IDLE: begin
          state_r <= SDCL_SHIFT;
        end
        SDCL_SHIFT: begin
          if (pins.sclk_rise && bits_r == BITS_FULL - 5'h01) begin
            state_r <= SDCL_DONE;
          end
        end
        SDCL_DONE: begin
          state_r <= SDCL_DONE;
        end
        // the fourth code is never entered; recover through idle
        default: begin
          state_r <= SDCL_IDLE;
        end
      endcase
    end
  end

  // rising clocks of this frame; a new frame restarts the count
  // counted from idle too: a clock may arrive with no setup after select
  // falls, and it must not be lost from the count
  always_ff @(posedge clk) begin
    if (reset) begin
      bits_r <= BITS_RST;
    end else if (pins.sel_n) begin
      bits_r <= BITS_RST;
    end else if (pins.sclk_rise && state_r != SDCL_DONE) begin
      bits_r <= bits_r + 5'h01;
    end
  end

  // extra clocks after 16 keep shifting; the last 16 bits win
  always_ff @(posedge clk) begin
    if (reset) begin
      code_r <= CODE_RST;
    end else if (pins.cs_rise) begin
      code_r <= shift_r;
    end
  end

  // the ladder code changes only one cycle after the code register, so
  // a select rise reaches the output about four clocks after it happens
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_code_input <= CODE_RST;
    end else begin
      serial_code_input <= code_r;
    end
  end

  // status only; it drops with select, not with the load
  always_ff @(posedge clk) begin
    if (reset) begin
      word_done <= 1'b0;
    end else begin
      word_done <= (state_r == SDCL_DONE);
    end
  end

  // shift register and code register

  hold_sel_high_a: assert property (@(posedge clk) disable iff (reset)
    pins.sel_n && !pins.cs_rise |=> $stable(shift_r) && $stable(code_r))
    else $error("state changed with select high");

  shift_one_a: assert property (@(posedge clk) disable iff (reset)
    !pins.sel_n && pins.sclk_rise |=>
      shift_r == {$past(shift_r[14:0]), $past(pins.din)})
    else $error("shift did not advance one bit");

  code_hold_a: assert property (@(posedge clk) disable iff (reset)
    !pins.sel_n |=> $stable(code_r))
    else $error("code changed with select low");

  load_on_rise_a: assert property (@(posedge clk) disable iff (reset)
    pins.cs_rise |=> code_r == $past(shift_r))
    else $error("code not loaded on select rise");

  sample_rise_a: assert property (@(posedge clk) disable iff (reset)
    !pins.sclk_rise |=> $stable(shift_r))
    else $error("shift without rising clock");

  msb_first_a: assert property (@(posedge clk) disable iff (reset)
    !pins.sel_n && pins.sclk_rise |=> shift_r[0] == $past(pins.din))
    else $error("new bit not at bit 0");

  // frame state and count

  sixteen_done_a: assert property (@(posedge clk) disable iff (reset)
    state_r == SDCL_SHIFT && pins.sclk_rise && !pins.sel_n &&
    bits_r == 5'h0f |=> state_r == SDCL_DONE)
    else $error("word not done on 16th clock");

  idle_count_a: assert property (@(posedge clk) disable iff (reset)
    pins.sel_n |=> bits_r == BITS_RST)
    else $error("count not cleared");

  count_step_a: assert property (@(posedge clk) disable iff (reset)
    !pins.sel_n && pins.sclk_rise && state_r != SDCL_DONE |=>
      bits_r == $past(bits_r) + 5'h01)
    else $error("count did not step on a clock");

  count_hold_a: assert property (@(posedge clk) disable iff (reset)
    !pins.sel_n && !pins.sclk_rise |=> $stable(bits_r))
    else $error("count moved without a clock");

  count_cap_a: assert property (@(posedge clk) disable iff (reset)
    bits_r <= BITS_FULL)
    else $error("count ran past sixteen");

  state_legal_a: assert property (@(posedge clk) disable iff (reset)
    state_r inside {SDCL_IDLE, SDCL_SHIFT, SDCL_DONE})
    else $error("illegal frame state");

  idle_state_a: assert property (@(posedge clk) disable iff (reset)
    pins.sel_n |=> state_r == SDCL_IDLE)
    else $error("frame kept with select high");

  frame_start_a: assert property (@(posedge clk) disable iff (reset)
    state_r == SDCL_IDLE && !pins.sel_n |=> state_r != SDCL_IDLE)
    else $error("frame did not start on select low");

  done_hold_a: assert property (@(posedge clk) disable iff (reset)
    state_r == SDCL_DONE && !pins.sel_n |=> state_r == SDCL_DONE)
    else $error("done state left with select low");

  // outputs

  out_follow_a: assert property (@(posedge clk) disable iff (reset)
    pins.cs_rise |=> ##1 serial_code_input == $past(shift_r, 2))
    else $error("output not updated after load");

  out_hold_a: assert property (@(posedge clk) disable iff (reset)
    !pins.cs_rise |=> ##1 $stable(serial_code_input))
    else $error("output changed without a load");

  done_flag_a: assert property (@(posedge clk) disable iff (reset)
    state_r == SDCL_DONE |=> word_done)
    else $error("done flag not raised");

  done_clear_a: assert property (@(posedge clk) disable iff (reset)
    state_r != SDCL_DONE |=> !word_done)
    else $error("done flag raised early");

  reset_out_a: assert property (@(posedge clk)
    reset |=> serial_code_input == CODE_RST && !word_done)
    else $error("outputs not cleared by reset");

  word_cov: cover property (@(posedge clk) disable iff (reset)
    state_r == SDCL_DONE ##[1:200] pins.cs_rise);
  short_cov: cover property (@(posedge clk) disable iff (reset)
    state_r == SDCL_SHIFT && bits_r == 5'h04 ##[1:200] pins.cs_rise);
  load_cov: cover property (@(posedge clk) disable iff (reset)
    pins.cs_rise ##2 serial_code_input != 16'h0000);
  stray_cov: cover property (@(posedge clk) disable iff (reset)
    pins.sel_n && pins.sclk_rise);
  reload_cov: cover property (@(posedge clk) disable iff (reset)
    pins.cs_rise ##[3:400] pins.cs_rise);
endmodule : sdcl_loader
`default_nettype wire

// ===== sdcl_master.sv
// serial master model driving the loader pins
`timescale 1ns/1ps
`default_nettype none
module sdcl_master (
  output var logic cs_n, // chip select, active low
  output var logic sclk, // serial clock, still outside frames except during pulse
  output var logic sdi // serial data
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // sends the low n bits of w, msb first, leaving select low
  task automatic send(input logic [15:0] w, input int n);
    cs_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = w[i];
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
  endtask : send
  task automatic stop;
    #100 cs_n = 1'b1;
    sdi = ~sdi;
    #200;
  endtask : stop
  // stray clocks with select high, only when a test asks
  task automatic pulse(input int n);
    repeat (n) begin
      sdi = ~sdi;
      #100 sclk = 1'b1;
      #100 sclk = 1'b0;
    end
  endtask : pulse
endmodule : sdcl_master
`default_nettype wire

// ===== test_sdcl_loader.sv
// self-checking bench for the serial code loader
`timescale 1ns/1ps
`default_nettype none
module test_sdcl_loader;
  import sdcl_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  wire logic cs_n;
  wire logic sclk;
  wire logic sdi;
  logic [15:0] code;
  logic done;
  logic [15:0] prev;
  int num_errors = 0;
  int checked = 0;
  logic [15:0] rows [4] = '{16'h0000, 16'hffff, 16'ha5c3, 16'h8001};
  always #12.5 clk = ~clk;
  sdcl_master m (.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
  sdcl_loader dut (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
    .sdi(sdi), .serial_code_input(code), .word_done(done));
  task automatic check(input string name, input logic [15:0] seen,
    input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    check("code at reset", code, CODE_RST);
    check("done at reset", {15'h0000, done}, 16'h0000);
    repeat (3) @(posedge clk);
    prev = CODE_RST;
    foreach (rows[i]) begin
      m.send(rows[i], 16);
      #200 check("done", {15'h0000, done}, 16'h0001);
      check("code held", code, prev);
      m.stop();
      check("code", code, rows[i]);
      check("done off", {15'h0000, done}, 16'h0000);
      prev = rows[i];
    end
    // short frame loads old bits shifted up
    m.send(16'h003c, 8);
    #200 check("done short", {15'h0000, done}, 16'h0000);
    m.stop();
    check("short code", code, 16'h013c);
    m.pulse(5);
    #200 check("idle clocks", code, 16'h013c);
    m.send(16'h0077, 8);
    m.stop();
    check("after idle", code, 16'h3c77);
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    check("code mid reset", code, CODE_RST);
    check("done mid reset", {15'h0000, done}, 16'h0000);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    m.send(16'h5a3c, 16);
    #200 check("done after reset", {15'h0000, done}, 16'h0001);
    m.stop();
    check("code after reset", code, 16'h5a3c);
    final_report();
  end
endmodule : test_sdcl_loader
`default_nettype wire
